// file: rtl/dual_fifo_pkg.sv
// Purpose: Shared constants and carrier types of the dual queue mailbox.
// Assumes: One system clock; port clocks arrive as sampled inputs.
// Notes:   Offsets are 8-bit counts of words.
package dual_fifo_pkg;
    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int WORD_W = 36;
    localparam int QUEUE_DEPTH = 256;
    localparam int OFF_W = 8;
    localparam int COUNT_W = 9;
    localparam int PROG_WRITES = 4;

    // ****************************************************************
    // Offset presets, selected by {offset_select_hi, offset_select_lo}
    // ****************************************************************
    localparam logic [1:0] SEL_PROGRAM = 2'h0;
    localparam logic [1:0] SEL_LOW = 2'h1;
    localparam logic [1:0] SEL_MID = 2'h2;
    localparam logic [1:0] SEL_HIGH = 2'h3;
    localparam logic [OFF_W-1:0] PRESET_LOW = 8'h08;
    localparam logic [OFF_W-1:0] PRESET_MID = 8'h10;
    localparam logic [OFF_W-1:0] PRESET_HIGH = 8'h40;
    localparam logic [OFF_W-1:0] OFFSET_RESET = 8'h08;

    // ****************************************************************
    // Programming order of the four offset loads
    // ****************************************************************
    localparam logic [1:0] PROG_FULL_AB = 2'h0;
    localparam logic [1:0] PROG_EMPTY_AB = 2'h1;
    localparam logic [1:0] PROG_FULL_BA = 2'h2;
    localparam logic [1:0] PROG_EMPTY_BA = 2'h3;

    // Control pins of one port; direction polarity differs per port
    typedef struct packed {
        logic select_n;
        logic direction;
        logic enable;
        logic mailbox_sel;
    } port_ctrl_t;

    // Decoded transfer kinds of one port
    typedef struct packed {
        logic q_wr;
        logic q_rd;
        logic mb_wr;
        logic mb_rd;
    } xfer_t;
endpackage

// file: rtl/bidirectional_dual_fifo_mailbox.sv
// Purpose: Two opposite queues with mailboxes between ports A and B.
// Assumes: Port clocks and resets are synchronous inputs sampled by i_clk.
// Notes:   Port clock rising edges are detected and used as transfer strobes.
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// Generic word queue with valid/ready on both sides
// ********************************************************************
module word_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_clear,
    // Filling side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Draining side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    // Fill level
    output logic [CNT_W-1:0] o_count
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    wire push = i_in_valid & o_in_ready;
    wire pop = o_out_valid & i_out_ready;

    // Full and empty come from the true count
    assign o_in_ready = o_count != CNT_W'(DEPTH);
    assign o_out_valid = o_count != '0;
    assign o_out_data = mem[rd_ptr];

    // Storage array
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            o_count <= '0;
        end else if (i_clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            o_count <= '0;
        end else begin
            wr_ptr <= push ? PTR_W'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= pop ? PTR_W'(rd_ptr + 1'b1) : rd_ptr;
            o_count <= CNT_W'(o_count + CNT_W'(push) - CNT_W'(pop));
        end
    end
endmodule

// ********************************************************************
// One direction: queue, output register, mailbox and port flags
// ********************************************************************
module queue_lane
    import dual_fifo_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_qreset_n,
    // Writing port
    input wire logic i_wr_edge,
    input wire logic i_wr_req,
    input wire logic i_divert,
    input wire logic i_mb_wr,
    input wire logic [WORD_W-1:0] i_data,
    input wire logic i_ir_block,
    // Reading port
    input wire logic i_rd_edge,
    input wire logic i_rd_req,
    input wire logic i_mb_rd,
    // Offsets
    input wire logic [OFF_W-1:0] i_empty_off,
    input wire logic [OFF_W-1:0] i_full_off,
    // Flags and words
    output logic o_accept,
    output logic o_ir,
    output logic o_or,
    output logic o_ae_n,
    output logic o_af_n,
    output logic o_mb_full_n,
    output logic [WORD_W-1:0] o_q_word,
    output logic [WORD_W-1:0] o_mb_word
);
    logic f_in_ready;
    logic f_out_valid;
    logic [WORD_W-1:0] f_out_data;
    logic [COUNT_W-1:0] f_count;
    logic ir_s0;
    logic af_s0;
    logic avail_s0;
    logic avail_s1;
    logic ae_s0;

    // Write acceptance and prefetch decisions
    assign o_accept = i_wr_edge & i_wr_req & o_ir;
    wire push = o_accept & ~i_divert;
    wire take = (~o_or & avail_s1) | (o_or & i_rd_req);
    wire pop = i_rd_edge & take & f_out_valid;
    wire [COUNT_W-1:0] after_push = COUNT_W'(f_count + COUNT_W'(push));
    wire room = after_push < COUNT_W'(QUEUE_DEPTH);
    wire [COUNT_W-1:0] full_mark = COUNT_W'(COUNT_W'(QUEUE_DEPTH) - COUNT_W'(i_full_off));
    wire af_raw = ~(f_count >= full_mark);
    wire ae_raw = f_count > COUNT_W'(i_empty_off);

    word_fifo #(.WIDTH(WORD_W), .DEPTH(QUEUE_DEPTH), .CNT_W(COUNT_W)) u_fifo (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clear(~i_qreset_n),
        .i_in_valid(push),
        .o_in_ready(f_in_ready),
        .i_in_data(i_data),
        .o_out_valid(f_out_valid),
        .i_out_ready(pop),
        .o_out_data(f_out_data),
        .o_count(f_count)
    );

    // Writer-side flags: two stages on writer edges, falling at once when full
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ir_s0 <= 1'b0;
            o_ir <= 1'b0;
            af_s0 <= 1'b1;
            o_af_n <= 1'b1;
        end else if (!i_qreset_n || i_ir_block) begin
            ir_s0 <= 1'b0;
            o_ir <= 1'b0;
            af_s0 <= 1'b1;
            o_af_n <= 1'b1;
        end else if (i_wr_edge) begin
            ir_s0 <= f_in_ready;
            o_ir <= ir_s0 & room;
            af_s0 <= af_raw;
            o_af_n <= af_s0;
        end
    end

    // Reader-side flags and output register prefetch
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            avail_s0 <= 1'b0;
            avail_s1 <= 1'b0;
            o_or <= 1'b0;
            ae_s0 <= 1'b0;
            o_ae_n <= 1'b0;
            o_q_word <= '0;
        end else if (!i_qreset_n) begin
            avail_s0 <= 1'b0;
            avail_s1 <= 1'b0;
            o_or <= 1'b0;
            ae_s0 <= 1'b0;
            o_ae_n <= 1'b0;
        end else if (i_rd_edge) begin
            avail_s0 <= f_out_valid;
            avail_s1 <= avail_s0;
            ae_s0 <= ae_raw;
            o_ae_n <= ae_s0;
            if (pop) begin
                o_q_word <= f_out_data;
                o_or <= 1'b1;
            end else if (take) begin
                o_or <= 1'b0;
            end
        end
    end

    // Mailbox: a write to an empty mailbox wins over a read in the same cycle; when full, the read wins
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mb_full_n <= 1'b1;
            o_mb_word <= '0;
        end else if (!i_qreset_n) begin
            o_mb_full_n <= 1'b1;
        end else if (i_wr_edge && i_mb_wr && o_mb_full_n) begin
            o_mb_word <= i_data;
            o_mb_full_n <= 1'b0;
        end else if (i_rd_edge && i_mb_rd) begin
            o_mb_full_n <= 1'b1;
        end
    end

    mb_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_qreset_n && i_wr_edge && i_mb_wr && o_mb_full_n |=> !o_mb_full_n && o_mb_word == $past(i_data))
        else $error("mailbox write did not land");
    mb_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !o_mb_full_n |=> $stable(o_mb_word))
        else $error("full mailbox was overwritten");
    prefetch_rise_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(o_or) |-> $past(i_rd_edge) && $past(avail_s1) && !$past(o_or))
        else $error("output ready rose without prefetch");
    word_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_or && !(i_rd_edge && i_rd_req) |=> $stable(o_q_word))
        else $error("output word moved without a read");
    write_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        push |-> o_ir && i_wr_edge && f_in_ready)
        else $error("queue write without input ready");
    ir_stages_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(o_ir) |-> $past(ir_s0) && $past(i_wr_edge))
        else $error("input ready skipped a stage");
endmodule

// ********************************************************************
// Top: port decode, offset registers and data pins
// ********************************************************************
module bidirectional_dual_fifo_mailbox
    import dual_fifo_pkg::*;
(
    // System
    input wire logic i_clk,
    input wire logic i_resetn,
    // Queue resets and offset selects
    input wire logic i_queue_ab_reset_n,
    input wire logic i_queue_ba_reset_n,
    input wire logic i_offset_select_hi,
    input wire logic i_offset_select_lo,
    // Port A
    input wire logic i_porta_clock,
    input wire dual_fifo_pkg::port_ctrl_t i_porta_ctrl,
    input wire logic [dual_fifo_pkg::WORD_W-1:0] i_porta_data,
    output logic [dual_fifo_pkg::WORD_W-1:0] o_porta_data,
    output logic o_porta_data_oe,
    output logic o_porta_input_ready,
    output logic o_porta_output_ready,
    output logic o_porta_almost_empty_n,
    output logic o_porta_almost_full_n,
    // Port B
    input wire logic i_portb_clock,
    input wire dual_fifo_pkg::port_ctrl_t i_portb_ctrl,
    input wire logic [dual_fifo_pkg::WORD_W-1:0] i_portb_data,
    output logic [dual_fifo_pkg::WORD_W-1:0] o_portb_data,
    output logic o_portb_data_oe,
    output logic o_portb_input_ready,
    output logic o_portb_output_ready,
    output logic o_portb_almost_empty_n,
    output logic o_portb_almost_full_n,
    // Mailbox flags
    output logic o_mailbox_ab_full_n,
    output logic o_mailbox_ba_full_n
);
    import dual_fifo_pkg::*;

    // Decode one port; write_level is the direction level meaning write
    function automatic xfer_t decode(input port_ctrl_t c, input logic write_level);
        xfer_t x;
        logic go;
        logic wr;
        go = ~c.select_n & c.enable;
        wr = c.direction == write_level;
        x.q_wr = go & wr & ~c.mailbox_sel;
        x.q_rd = go & ~wr & ~c.mailbox_sel;
        x.mb_wr = go & wr & c.mailbox_sel;
        x.mb_rd = go & ~wr & c.mailbox_sel;
        return x;
    endfunction

    // Preset chosen by the selects
    function automatic logic [OFF_W-1:0] preset(input logic [1:0] sel);
        case (sel)
            SEL_HIGH: preset = PRESET_HIGH;
            SEL_MID: preset = PRESET_MID;
            SEL_LOW: preset = PRESET_LOW;
            default: preset = OFFSET_RESET;
        endcase
    endfunction

    logic porta_clock_q;
    logic portb_clock_q;
    logic ab_reset_q;
    logic ba_reset_q;
    logic prog_active;
    logic [1:0] prog_cnt;
    logic [OFF_W-1:0] full_offset_ab;
    logic [OFF_W-1:0] empty_offset_ab;
    logic [OFF_W-1:0] full_offset_ba;
    logic [OFF_W-1:0] empty_offset_ba;
    logic ab_accept;
    logic [WORD_W-1:0] q_ab_word;
    logic [WORD_W-1:0] q_ba_word;
    logic [WORD_W-1:0] mb_ab_word;
    logic [WORD_W-1:0] mb_ba_word;

    // Edges of port clocks and reset releases
    wire a_edge = i_porta_clock & ~porta_clock_q;
    wire b_edge = i_portb_clock & ~portb_clock_q;
    wire ab_rise = i_queue_ab_reset_n & ~ab_reset_q;
    wire ba_rise = i_queue_ba_reset_n & ~ba_reset_q;
    wire [1:0] sel = {i_offset_select_hi, i_offset_select_lo};
    wire xfer_t a_x = decode(i_porta_ctrl, 1'b1);
    wire xfer_t b_x = decode(i_portb_ctrl, 1'b0);
    wire prog_take = prog_active & ab_accept;

    // Edge history
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            porta_clock_q <= 1'b1; // High so no false edge follows reset
            portb_clock_q <= 1'b1;
            ab_reset_q <= 1'b1;
            ba_reset_q <= 1'b1;
        end else begin
            porta_clock_q <= i_porta_clock;
            portb_clock_q <= i_portb_clock;
            ab_reset_q <= i_queue_ab_reset_n;
            ba_reset_q <= i_queue_ba_reset_n;
        end
    end

    // Offset presets at reset release, or serial loading from port A
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            full_offset_ab <= OFFSET_RESET;
            empty_offset_ab <= OFFSET_RESET;
            full_offset_ba <= OFFSET_RESET;
            empty_offset_ba <= OFFSET_RESET;
            prog_active <= 1'b0;
            prog_cnt <= 2'h0;
        end else begin
            if (ab_rise && sel != SEL_PROGRAM) begin
                full_offset_ab <= preset(sel);
                empty_offset_ab <= preset(sel);
            end
            if (ba_rise && sel != SEL_PROGRAM) begin
                full_offset_ba <= preset(sel);
                empty_offset_ba <= preset(sel);
            end
            if (ab_rise && sel == SEL_PROGRAM) begin
                prog_active <= 1'b1;
                prog_cnt <= 2'h0;
            end else if (prog_take) begin
                case (prog_cnt)
                    PROG_FULL_AB: full_offset_ab <= i_porta_data[OFF_W-1:0];
                    PROG_EMPTY_AB: empty_offset_ab <= i_porta_data[OFF_W-1:0];
                    PROG_FULL_BA: full_offset_ba <= i_porta_data[OFF_W-1:0];
                    PROG_EMPTY_BA: empty_offset_ba <= i_porta_data[OFF_W-1:0];
                    default: full_offset_ab <= full_offset_ab;
                endcase
                prog_cnt <= 2'(prog_cnt + 1'b1);
                prog_active <= prog_cnt != 2'(PROG_WRITES - 1);
            end
        end
    end

    // Queue from port A to port B
    queue_lane u_ab (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_qreset_n(i_queue_ab_reset_n),
        .i_wr_edge(a_edge),
        .i_wr_req(a_x.q_wr),
        .i_divert(prog_active),
        .i_mb_wr(a_x.mb_wr),
        .i_data(i_porta_data),
        .i_ir_block(1'b0),
        .i_rd_edge(b_edge),
        .i_rd_req(b_x.q_rd),
        .i_mb_rd(b_x.mb_rd),
        .i_empty_off(empty_offset_ab),
        .i_full_off(full_offset_ab),
        .o_accept(ab_accept),
        .o_ir(o_porta_input_ready),
        .o_or(o_portb_output_ready),
        .o_ae_n(o_portb_almost_empty_n),
        .o_af_n(o_porta_almost_full_n),
        .o_mb_full_n(o_mailbox_ab_full_n),
        .o_q_word(q_ab_word),
        .o_mb_word(mb_ab_word)
    );

    // Queue from port B to port A; blocked while offsets load
    queue_lane u_ba (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_qreset_n(i_queue_ba_reset_n),
        .i_wr_edge(b_edge),
        .i_wr_req(b_x.q_wr),
        .i_divert(1'b0),
        .i_mb_wr(b_x.mb_wr),
        .i_data(i_portb_data),
        .i_ir_block(prog_active),
        .i_rd_edge(a_edge),
        .i_rd_req(a_x.q_rd),
        .i_mb_rd(a_x.mb_rd),
        .i_empty_off(empty_offset_ba),
        .i_full_off(full_offset_ba),
        .o_accept(),
        .o_ir(o_portb_input_ready),
        .o_or(o_porta_output_ready),
        .o_ae_n(o_porta_almost_empty_n),
        .o_af_n(o_portb_almost_full_n),
        .o_mb_full_n(o_mailbox_ba_full_n),
        .o_q_word(q_ba_word),
        .o_mb_word(mb_ba_word)
    );

    // Data pins: drive and word selection follow the control pins
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_porta_data <= '0;
            o_porta_data_oe <= 1'b0;
            o_portb_data <= '0;
            o_portb_data_oe <= 1'b0;
        end else begin
            o_porta_data_oe <= ~i_porta_ctrl.select_n & ~i_porta_ctrl.direction;
            o_porta_data <= i_porta_ctrl.mailbox_sel ? mb_ba_word : q_ba_word;
            o_portb_data_oe <= ~i_portb_ctrl.select_n & i_portb_ctrl.direction;
            o_portb_data <= i_portb_ctrl.mailbox_sel ? mb_ab_word : q_ab_word;
        end
    end

    oe_a_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_porta_data_oe == $past(!i_porta_ctrl.select_n && !i_porta_ctrl.direction))
        else $error("port A drive mismatch");
    oe_b_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_portb_data_oe == $past(!i_portb_ctrl.select_n && i_portb_ctrl.direction))
        else $error("port B drive mismatch");
    prog_block_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        prog_active && $past(prog_active) |-> !o_portb_input_ready)
        else $error("port B ready during offset loading");
    prog_first_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        prog_take && prog_cnt == PROG_FULL_AB |=> full_offset_ab == $past(i_porta_data[7:0]))
        else $error("first load did not reach full offset ab");
    prog_end_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        prog_take && prog_cnt == PROG_EMPTY_BA |=> !prog_active)
        else $error("loading did not end after four writes");
    enable_low_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_porta_ctrl.enable |-> !ab_accept)
        else $error("port A transfer with enable low");
    preset_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ab_rise && sel == SEL_HIGH |=> full_offset_ab == 8'h40 && empty_offset_ab == 8'h40)
        else $error("preset not loaded");
endmodule

`default_nettype wire

// file: testbench/portb_host.sv
// Purpose: Port B host model that reads queue_ab words or writes mailbox_ba.
// Assumes: Port clock of six system cycles, four high and two low.
// Notes:   Captures the shown word on every accepted read edge.
`timescale 1ns/1ps
`default_nettype none
module portb_host
    import dual_fifo_pkg::*;
(
    // System
    input wire logic i_clk,
    input wire logic i_resetn,
    // Bench control
    input wire logic i_stall,
    input wire logic i_mail,
    // Device side
    input wire logic i_output_ready,
    input wire logic [WORD_W-1:0] i_data,
    output logic o_clock,
    output port_ctrl_t o_ctrl,
    output logic [WORD_W-1:0] o_bus,
    // Captured words
    output logic o_got,
    output logic [WORD_W-1:0] o_word
);
    logic [2:0] cnt;
    // Clock, read decode set while the clock is low, capture on the rising edge
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt <= 3'h0;
            o_clock <= 1'b0;
            o_ctrl <= 4'h8;
            o_bus <= '0;
            o_got <= 1'b0;
            o_word <= '0;
        end else begin
            cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
            o_clock <= (cnt >= 3'h2);
            if (cnt == 3'h0) begin
                o_ctrl <= {1'b0, ~i_mail, ~i_stall, i_mail};
            end
            // Mail word held while writing; otherwise every bit of the bus keeps toggling
            o_bus <= o_ctrl.direction ? ~o_bus : 36'h9_8765_4321;
            o_got <= (cnt == 3'h3) & o_ctrl.enable & o_ctrl.direction & i_output_ready;
            o_word <= i_data;
        end
    end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: Self-checking bench of the dual queue mailbox.
// Assumes: Port A clock made here, two cycles high and two low.
// Notes:   Port B is the reader model; words are compared in order.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin failures++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
    import dual_fifo_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, rab = 1'b0, rba = 1'b0, shi = 1'b0, slo = 1'b0;
    logic pa_clk = 1'b0, stall = 1'b0, mail = 1'b0;
    port_ctrl_t pa_ctrl = 4'h8;
    logic [WORD_W-1:0] pa_data = '0;
    logic pb_clk, got;
    port_ctrl_t pb_ctrl;
    logic [WORD_W-1:0] pb_bus, pb_out, word, pa_out;
    logic pa_oe, ir_a, or_a, ae_a, af_a, pb_oe, ir_b, or_b, ae_b, af_b, mbf_ab, mbf_ba;
    logic [WORD_W-1:0] rx[$];
    int failures = 0, n_tests = 0;
    // ****************************************************************
    // Device and port B host
    // ****************************************************************
    bidirectional_dual_fifo_mailbox dut (.i_clk(clk), .i_resetn(resetn),
        .i_queue_ab_reset_n(rab), .i_queue_ba_reset_n(rba), .i_offset_select_hi(shi),
        .i_offset_select_lo(slo), .i_porta_clock(pa_clk), .i_porta_ctrl(pa_ctrl),
        .i_porta_data(pa_data), .o_porta_data(pa_out), .o_porta_data_oe(pa_oe),
        .o_porta_input_ready(ir_a), .o_porta_output_ready(or_a),
        .o_porta_almost_empty_n(ae_a), .o_porta_almost_full_n(af_a),
        .i_portb_clock(pb_clk), .i_portb_ctrl(pb_ctrl), .i_portb_data(pb_bus),
        .o_portb_data(pb_out), .o_portb_data_oe(pb_oe), .o_portb_input_ready(ir_b),
        .o_portb_output_ready(or_b), .o_portb_almost_empty_n(ae_b),
        .o_portb_almost_full_n(af_b), .o_mailbox_ab_full_n(mbf_ab),
        .o_mailbox_ba_full_n(mbf_ba));
    portb_host host (.i_clk(clk), .i_resetn(resetn), .i_stall(stall), .i_mail(mail),
        .i_output_ready(or_b), .i_data(pb_out), .o_clock(pb_clk), .o_ctrl(pb_ctrl),
        .o_bus(pb_bus), .o_got(got), .o_word(word));
    // Clock and collection of words read on port B
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (got === 1'b1) begin
            rx.push_back(word);
        end
    end
    // One port A clock period with control and data set while low
    task automatic a_cyc(input port_ctrl_t c, input logic [WORD_W-1:0] d);
        @(posedge clk) pa_clk <= 1'b0;
        pa_ctrl <= c;
        pa_data <= d;
        @(posedge clk);
        @(posedge clk) pa_clk <= 1'b1;
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        repeat (n) a_cyc(4'h8, '0);
    endtask
    // Both queue resets low across seven edges of the port A clock and at least four of the port B clock
    task automatic qreset(input logic [1:0] sel);
        @(posedge clk) {shi, slo} <= sel;
        rab <= 1'b0;
        rba <= 1'b0;
        idle(7);
        @(posedge clk) rab <= 1'b1;
        rba <= 1'b1;
        idle(3);
    endtask
    task automatic t_preset();
        qreset(2'h3);
        `CHK("ir_a", 1'b1, ir_a)
        `CHK("ae_b", 1'b0, ae_b)
        `CHK("af_a", 1'b1, af_a)
        `CHK("mbf_ab", 1'b1, mbf_ab)
        `CHK("mbf_ba", 1'b1, mbf_ba)
        `CHK("or_a", 1'b0, or_a)
        `CHK("ae_a", 1'b0, ae_a)
        `CHK("af_b", 1'b1, af_b)
        `CHK("pb_oe", 1'b1, pb_oe)
    endtask
    task automatic t_transfer();
        rx.delete();
        a_cyc(4'h6, 36'h1_2345_6789);
        a_cyc(4'h4, 36'hF_0000_000F);
        a_cyc(4'h6, 36'hA_BCDE_F012);
        idle(12);
        `CHK("rx_n", 2, rx.size())
        `CHK("rx0", 36'h1_2345_6789, rx[0])
        `CHK("rx1", 36'hA_BCDE_F012, rx[1])
    endtask
    task automatic t_mailbox_pins();
        a_cyc(4'h7, 36'h5_5555_5555);
        idle(1);
        `CHK("mbf_ab", 1'b0, mbf_ab)
        a_cyc(4'h0, '0);
        `CHK("pa_oe", 1'b1, pa_oe)
        a_cyc(4'h4, '0);
        `CHK("pa_oe", 1'b0, pa_oe)
        mail <= 1'b1;
        idle(4);
        mail <= 1'b0;
        `CHK("mbf_ba", 1'b0, mbf_ba)
        a_cyc(4'h1, '0);
        `CHK("pa_out", 36'h9_8765_4321, pa_out)
        a_cyc(4'h3, '0);
        idle(1);
        `CHK("mbf_ba", 1'b1, mbf_ba)
    endtask
    // Preset of eight: tenth written word lifts almost-empty, then drain all ten
    task automatic t_preset_low();
        qreset(2'h1);
        rx.delete();
        stall <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            a_cyc(4'h6, WORD_W'(i));
        end
        idle(5);
        `CHK("ae_b", 1'b0, ae_b)
        a_cyc(4'h6, WORD_W'(9));
        idle(5);
        `CHK("ae_b", 1'b1, ae_b)
        stall <= 1'b0;
        idle(20);
        `CHK("rx_n", 10, rx.size())
        `CHK("rx9", 36'h0_0000_0009, rx[9])
    endtask
    task automatic t_program();
        qreset(2'h0);
        a_cyc(4'h6, 36'hF_FFFF_FF02);
        a_cyc(4'h6, 36'hF_FFFF_FF01);
        a_cyc(4'h6, 36'hF_FFFF_FF03);
        idle(6);
        `CHK("ir_b", 1'b0, ir_b)
        a_cyc(4'h6, 36'hF_FFFF_FF04);
        idle(6);
        `CHK("ir_b", 1'b1, ir_b)
        rx.delete();
        stall <= 1'b1;
        for (int i = 1; i <= 3; i++) begin
            a_cyc(4'h6, WORD_W'(i));
        end
        idle(8);
        `CHK("ae_b", 1'b1, ae_b)
        stall <= 1'b0;
        idle(14);
        `CHK("rx_n", 3, rx.size())
        `CHK("rx0", 36'h0_0000_0001, rx[0])
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Main sequence after three reset cycles, and the watchdog
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        t_preset();
        t_transfer();
        t_mailbox_pins();
        t_preset_low();
        t_program();
        print_verdict();
    end
    initial begin
        #2000000;
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
